/* hdl/psc_pkg.sv */
// package of constants for the strap capture and led polarity block
//
// Functional notes
// - only one mac interface mode at once
// - gigabit mode for 1000, mii for 10/100
// - reference select high 125 MHz, low 25 MHz
// - pll multiplier derived from single reference
// - five address straps give 32 addresses
// - address zero forces power-down isolate mode
// - management registers stay served while isolated
// - clearing control bit 11 leaves isolate
// - address straps latched, readable at 0x10
// - address bits 0..4 share five led pins
// - strap low gives active-high led
// - polarity choice applies to every led pin
// - reset low 140 us relatches all straps
`default_nettype none

package psc_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses, 16-bit data)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STRAP = 8'h10;
   localparam int CTRL_ISO_BIT = 11;
   localparam int STRAP_ADDR_LSB = 0;
   localparam int STRAP_REFSEL_BIT = 5;
   localparam int STRAP_POL_LSB = 8;
   localparam int MGMT_ADDR_W = 5;
   localparam logic [4:0] MGMT_ADDR_ISO = 5'h00;

   // ---------------------------------------------------------------
   // link speed code from the negotiation logic
   // ---------------------------------------------------------------
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;

   // ---------------------------------------------------------------
   // pll multiplier towards a 1000 MHz internal clock
   // ---------------------------------------------------------------
   localparam int REF_125_MHZ = 125;
   localparam int REF_25_MHZ = 25;
   localparam int PLL_VCO_MHZ = 1000;
   localparam logic [7:0] PLL_MULT_125 = 8'(PLL_VCO_MHZ / REF_125_MHZ);
   localparam logic [7:0] PLL_MULT_25 = 8'(PLL_VCO_MHZ / REF_25_MHZ);

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int RESET_MIN_US = 140;
   localparam int RESET_MIN_CYC = RESET_MIN_US * CLK_MHZ;
   localparam logic [3:0] STRAP_SETTLE_CYC = 4'h4;

   // capture sequencer, gray along the path
   typedef enum logic [1:0] {
      ST_SETTLE = 2'h0,
      ST_CAPTURE = 2'h1,
      ST_RUN = 2'h3
   } psc_state_t;

endpackage

`default_nettype wire

/* hdl/psc_sync.sv */
// two-stage synchroniser for pin inputs
`default_nettype none

module psc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule

`default_nettype wire

/* hdl/psc_led_drv.sv */
// led pin drivers with strap dependent polarity
`default_nettype none

module psc_led_drv #(
   parameter int NUM_LED = 7
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_run,
   input wire logic [NUM_LED-1:0] i_pol,
   input wire logic [NUM_LED-1:0] i_act,
   output logic [NUM_LED-1:0] o_pin_out,
   output logic [NUM_LED-1:0] o_pin_oe
);

   logic [NUM_LED-1:0] out_q;
   logic [NUM_LED-1:0] out_d;
   logic [NUM_LED-1:0] oe_q;
   logic [NUM_LED-1:0] oe_d;

   // -----------------------------------------------------------------
   // per pin polarity
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_LED; g++) begin : g_led
         // latched 1 inverts, so the led lights when the pin goes low
         always_comb begin
            out_d[g] = i_run ? (i_act[g] ^ i_pol[g]) : 1'b0;
            oe_d[g] = i_run;
         end
      end
   endgenerate

   // register pins so they are glitch free
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         out_q <= '0;
         oe_q <= '0;
      end else begin
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign o_pin_out = out_q;
   assign o_pin_oe = oe_q;

   a_led_polarity: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_run |=> o_pin_out == ($past(i_act) ^ $past(i_pol)))
      else $error("led pin level does not follow strap polarity");

   a_led_hold_in: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_run |=> o_pin_oe == '0)
      else $error("led pin driven before strap captured");

endmodule

`default_nettype wire

/* hdl/psc_strap_cfg.sv */
// strap capture, isolate control, mac mode and led polarity top
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`default_nettype none

module psc_strap_cfg #(
   parameter int NUM_LED = 7,
   parameter int RESET_MIN_CYC = psc_pkg::RESET_MIN_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // shared strap / led pins
   input wire logic [NUM_LED-1:0] i_led_pin_in,
   output logic [NUM_LED-1:0] o_led_pin_out,
   output logic [NUM_LED-1:0] o_led_pin_oe,
   input wire logic i_ref_sel,
   // indicator activity from the core, same clock
   input wire logic [NUM_LED-1:0] i_led_act,
   input wire logic [1:0] i_link_speed,
   // register port
   input wire logic [psc_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [psc_pkg::DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [psc_pkg::DATA_W-1:0] o_reg_rdata,
   // configuration results
   output logic [psc_pkg::MGMT_ADDR_W-1:0] o_mgmt_addr,
   output logic o_gmii_mode,
   output logic o_mii_mode,
   output logic o_line_tx_en,
   output logic o_line_rx_en,
   output logic o_gmii_io_en,
   output logic [7:0] o_pll_mult,
   output logic o_cfg_valid
);

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [NUM_LED-1:0] pin_sync;
   logic ref_sel_sync;

   psc_sync #(.WIDTH(NUM_LED + 1)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_async({i_ref_sel, i_led_pin_in}),
      .o_sync({ref_sel_sync, pin_sync})
   );

   // -----------------------------------------------------------------
   // capture sequencer
   // -----------------------------------------------------------------
   psc_pkg::psc_state_t state_q;
   psc_pkg::psc_state_t state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic capture;
   logic run;

   assign capture = (state_q == psc_pkg::ST_CAPTURE);
   assign run = (state_q == psc_pkg::ST_RUN);

   // wait until the synchroniser holds real pin levels, then sample once
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         psc_pkg::ST_SETTLE: begin
            if (cnt_q == 4'h0) begin
               state_d = psc_pkg::ST_CAPTURE;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         psc_pkg::ST_CAPTURE: begin
            state_d = psc_pkg::ST_RUN;
         end
         psc_pkg::ST_RUN: begin
            state_d = psc_pkg::ST_RUN;
         end
         default: begin
            state_d = psc_pkg::ST_SETTLE;
            cnt_d = psc_pkg::STRAP_SETTLE_CYC;
         end
      endcase
   end

   // every reset restarts the sequence, so straps are relatched
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= psc_pkg::ST_SETTLE;
         cnt_q <= psc_pkg::STRAP_SETTLE_CYC;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // -----------------------------------------------------------------
   // strap latches and control state
   // -----------------------------------------------------------------
   logic [NUM_LED-1:0] strap_q;
   logic [NUM_LED-1:0] strap_d;
   logic ref_sel_q;
   logic ref_sel_d;
   logic isolate_q;
   logic isolate_d;
   logic wr_ctrl;
   logic addr_zero;

   assign wr_ctrl = i_reg_wr && (i_reg_addr == psc_pkg::REG_CTRL);
   assign addr_zero = (pin_sync[psc_pkg::MGMT_ADDR_W-1:0] == psc_pkg::MGMT_ADDR_ISO);

   // hardware set at capture beats a same-cycle software clear
   always_comb begin
      strap_d = strap_q;
      ref_sel_d = ref_sel_q;
      isolate_d = isolate_q;
      if (wr_ctrl) begin
         isolate_d = i_reg_wdata[psc_pkg::CTRL_ISO_BIT];
      end
      if (capture) begin
         strap_d = pin_sync;
         ref_sel_d = ref_sel_sync;
         if (addr_zero) begin
            isolate_d = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strap_q <= '0;
         ref_sel_q <= 1'b0;
         isolate_q <= 1'b0;
      end else begin
         strap_q <= strap_d;
         ref_sel_q <= ref_sel_d;
         isolate_q <= isolate_d;
      end
   end

   // -----------------------------------------------------------------
   // mode, line enables and pll setting
   // -----------------------------------------------------------------
   logic gmii_q;
   logic gmii_d;
   logic mii_q;
   logic mii_d;
   logic tx_en_q;
   logic tx_en_d;
   logic rx_en_q;
   logic rx_en_d;
   logic gio_en_q;
   logic gio_en_d;
   logic [7:0] pll_q;
   logic [7:0] pll_d;
   logic valid_q;
   logic valid_d;

   // mii is the complement of gmii, so both can never be on together
   always_comb begin
      gmii_d = (i_link_speed == psc_pkg::SPEED_1000);
      mii_d = !gmii_d;
      tx_en_d = run && !isolate_q;
      rx_en_d = run && !isolate_q;
      gio_en_d = run && !isolate_q && gmii_d;
      pll_d = ref_sel_q ? psc_pkg::PLL_MULT_125 : psc_pkg::PLL_MULT_25;
      valid_d = run;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gmii_q <= 1'b0;
         mii_q <= 1'b1;
         tx_en_q <= 1'b0;
         rx_en_q <= 1'b0;
         gio_en_q <= 1'b0;
         pll_q <= psc_pkg::PLL_MULT_25;
         valid_q <= 1'b0;
      end else begin
         gmii_q <= gmii_d;
         mii_q <= mii_d;
         tx_en_q <= tx_en_d;
         rx_en_q <= rx_en_d;
         gio_en_q <= gio_en_d;
         pll_q <= pll_d;
         valid_q <= valid_d;
      end
   end

   // -----------------------------------------------------------------
   // register read port, never gated by isolate
   // -----------------------------------------------------------------
   logic [psc_pkg::DATA_W-1:0] rdata_q;
   logic [psc_pkg::DATA_W-1:0] rdata_d;

   // data stands one cycle only, zero otherwise and for unmapped addresses
   always_comb begin
      rdata_d = '0;
      if (i_reg_rd) begin
         case (i_reg_addr)
            psc_pkg::REG_CTRL: begin
               rdata_d[psc_pkg::CTRL_ISO_BIT] = isolate_q;
            end
            psc_pkg::REG_STRAP: begin
               rdata_d[psc_pkg::STRAP_ADDR_LSB +: psc_pkg::MGMT_ADDR_W] =
                  strap_q[psc_pkg::MGMT_ADDR_W-1:0];
               rdata_d[psc_pkg::STRAP_REFSEL_BIT] = ref_sel_q;
               rdata_d[psc_pkg::STRAP_POL_LSB +: NUM_LED] = strap_q;
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // -----------------------------------------------------------------
   // led drivers
   // -----------------------------------------------------------------
   psc_led_drv #(.NUM_LED(NUM_LED)) u_led (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_run(run),
      .i_pol(strap_q),
      .i_act(i_led_act),
      .o_pin_out(o_led_pin_out),
      .o_pin_oe(o_led_pin_oe)
   );

   assign o_reg_rdata = rdata_q;
   assign o_mgmt_addr = strap_q[psc_pkg::MGMT_ADDR_W-1:0];
   assign o_gmii_mode = gmii_q;
   assign o_mii_mode = mii_q;
   assign o_line_tx_en = tx_en_q;
   assign o_line_rx_en = rx_en_q;
   assign o_gmii_io_en = gio_en_q;
   assign o_pll_mult = pll_q;
   assign o_cfg_valid = valid_q;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_mode_exclusive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_gmii_mode != o_mii_mode)
      else $error("gmii and mii modes not exclusive");

   a_mode_speed: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_link_speed == psc_pkg::SPEED_1000 |=> o_gmii_mode)
      else $error("gigabit speed without gmii mode");

   a_pll_ref_sel: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      run && $past(run) |-> o_pll_mult == (ref_sel_q ? psc_pkg::PLL_MULT_125 : psc_pkg::PLL_MULT_25))
      else $error("pll multiplier disagrees with reference select");

   a_iso_on_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      capture && addr_zero |=> isolate_q ##1 (!o_line_tx_en && !o_gmii_io_en))
      else $error("address zero did not isolate");

   a_bus_served: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_reg_rd && i_reg_addr == psc_pkg::REG_CTRL && !wr_ctrl && !capture
      |=> o_reg_rdata[psc_pkg::CTRL_ISO_BIT] == isolate_q)
      else $error("control read wrong while isolated");

   a_iso_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_ctrl && !i_reg_wdata[psc_pkg::CTRL_ISO_BIT] && !capture
      |=> !isolate_q ##1 (o_line_rx_en == $past(run)))
      else $error("clearing isolate did not release line");

   a_addr_latch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      capture |=> o_mgmt_addr == $past(pin_sync[psc_pkg::MGMT_ADDR_W-1:0]))
      else $error("strap address not latched");

   a_capture_delay: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(run) |-> $past(capture) && !$past(run, 2))
      else $error("run entered without capture");

endmodule

`default_nettype wire

/* tb/psc_strap_board.sv */
// board-side model of the shared strap/led pins and the reference select strap
`default_nettype none

module psc_strap_board #(
   parameter int NUM_LED = 7
) (
   input wire logic [NUM_LED-1:0] i_pin_out,
   input wire logic [NUM_LED-1:0] i_pin_oe,
   input wire logic [NUM_LED-1:0] i_strap,
   input wire logic i_ref_strap,
   output logic [NUM_LED-1:0] o_pin_level,
   output logic o_ref_sel
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // pin resolution
   // ---------------------------------------------------------------
   // a released pin falls back to its pull resistor, never to the last driven level
   always_comb begin
      for (int i = 0; i < NUM_LED; i++) begin
         o_pin_level[i] = i_pin_oe[i] ? i_pin_out[i] : i_strap[i];
      end
   end

   // pull-up selects the fast reference, pull-down the slow one
   assign o_ref_sel = i_ref_strap;
endmodule

`default_nettype wire

/* tb/phy_strap_config_and_led_polarity_tb.sv */
// self-checking bench for the strap capture and led polarity block
`default_nettype none

module phy_strap_config_and_led_polarity_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] strap = 7'h03;
   logic ref_strap = 1'b1;
   logic [6:0] pin_level, pin_out, pin_oe, led_act = 7'h00;
   logic ref_sel;
   logic [1:0] speed = 2'h0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic [4:0] mgmt_addr;
   logic gmii, mii, tx_en, rx_en, gio_en, cfg_valid;
   logic [7:0] pll;
   int error_cnt = 0;
   int tests_run = 0;
   int m_iso;
   logic [15:0] got;
   logic [6:0] new_strap;

   always #10 clk = ~clk;

   psc_strap_board #(.NUM_LED(7)) u_psc_strap_board (.i_pin_out(pin_out), .i_pin_oe(pin_oe),
      .i_strap(strap), .i_ref_strap(ref_strap), .o_pin_level(pin_level), .o_ref_sel(ref_sel));

   psc_strap_cfg #(.NUM_LED(7)) u_psc_strap_cfg (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_led_pin_in(pin_level), .o_led_pin_out(pin_out), .o_led_pin_oe(pin_oe), .i_ref_sel(ref_sel),
      .i_led_act(led_act), .i_link_speed(speed), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_mgmt_addr(mgmt_addr),
      .o_gmii_mode(gmii), .o_mii_mode(mii), .o_line_tx_en(tx_en), .o_line_rx_en(rx_en),
      .o_gmii_io_en(gio_en), .o_pll_mult(pll), .o_cfg_valid(cfg_valid));

   // ---------------------------------------------------------------
   // checking and closing
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // register port master, one-cycle strobes
   // ---------------------------------------------------------------
   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // reset with a new strap set; the pins stay released until capture
   task automatic do_reset(input int cyc);
      int n;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (cyc) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(16'(pin_oe), 16'h0000);
      chk(16'(cfg_valid), 16'h0000);
      n = 0;
      while (cfg_valid !== 1'b1) begin
         @(posedge clk);
         #1 n++;
         if (n > 20) begin
            error_cnt++;
            $display("unexpected timeout at %0t: configuration never valid", $time);
            final_report();
         end
      end
      m_iso = (strap[4:0] == 5'h00);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'hf2d2a1d3));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int run = 0; run < 6; run++) begin
         new_strap = 7'($urandom());
         if (run == 1) new_strap[4:0] = 5'h00;
         if (run == 2) new_strap = 7'h7f;
         // straps change on an edge, before the reset that relatches them
         @(posedge clk);
         strap <= new_strap;
         ref_strap <= run[0];
         do_reset(run + 2);
         // strap capture, address, reference select
         chk(16'(mgmt_addr), 16'(strap[4:0]));
         chk(16'(pll), 16'(ref_strap ? psc_pkg::PLL_MULT_125 : psc_pkg::PLL_MULT_25));
         reg_rd(psc_pkg::REG_STRAP, got);
         chk(got, {1'b0, strap, 2'b00, ref_strap, strap[4:0]});
         chk(16'(pin_oe), 16'h007f);
         // isolate on address zero, register port still served
         chk(16'({tx_en, rx_en}), m_iso ? 16'h0000 : 16'h0003);
         reg_rd(psc_pkg::REG_CTRL, got);
         chk(got, m_iso ? 16'h0800 : 16'h0000);
         if (m_iso) begin
            reg_wr(psc_pkg::REG_CTRL, 16'h0000);
            repeat (2) @(posedge clk);
            #1 chk(16'({tx_en, rx_en}), 16'h0003);
            m_iso = 0;
         end
         // read-only and unmapped places
         reg_wr(psc_pkg::REG_STRAP, 16'hffff);
         reg_rd(psc_pkg::REG_STRAP, got);
         chk(got, {1'b0, strap, 2'b00, ref_strap, strap[4:0]});
         reg_rd(8'h20, got);
         chk(got, 16'h0000);
         // led polarity follows the latched strap of each pin
         for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            led_act <= 7'($urandom());
            @(posedge clk);
            #1 chk(16'(pin_out), 16'(led_act ^ strap));
         end
         // mac interface mode follows link speed, one mode at a time
         for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            speed <= 2'(s);
            repeat (2) @(posedge clk);
            #1 chk(16'({gmii, mii}), (s == 2) ? 16'h0002 : 16'h0001);
            chk(16'(gio_en), 16'((s == 2) && (m_iso == 0)));
         end
      end
      final_report();
   end
endmodule

`default_nettype wire
